// ===== nvsr_pkg.sv
// Package of constants for the nonvolatile store and restore command block
package nvsr_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [15:0] CMD_STORE = 16'hCC48;
  localparam logic [15:0] CMD_RESTORE_NV = 16'hCCB8;
  localparam logic [15:0] CMD_RESTORE_REST = 16'hCCB6;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h30A2;

  // ----------------------------------------
  // Memory layout
  // ----------------------------------------
  localparam int NV_WORDS = 4;
  localparam int NV_AW = 2;
  localparam int REST_WORDS = 4;
  localparam logic [1:0] IDX_CFG = 2'h0;
  localparam logic [1:0] IDX_ALARM_HI = 2'h1;
  localparam logic [1:0] IDX_ALARM_LO = 2'h2;
  localparam logic [1:0] IDX_SPARE = 2'h3;
  localparam logic [1:0] NV_LAST = 2'h3;

  // ----------------------------------------
  // Reset values and addressing
  // ----------------------------------------
  localparam logic [15:0] WORK_RST = 16'h0000;
  localparam logic [15:0] REST_RST = 16'h0000;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h44;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    NVSR_IDLE,
    NVSR_LOAD_RD,
    NVSR_LOAD_WR,
    NVSR_STORE,
    NVSR_REST_COPY
  } nvsr_op_e;

endpackage

// ===== nvsr_mem.sv
// Nonvolatile word store with registered read data
`timescale 1ns/100ps
module nvsr_mem (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] cells [0:nvsr_pkg::NV_WORDS-1];

  // ----------------------------------------
  // Write and registered read
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end

endmodule // nvsr_mem

// ===== nvsr_cmd.sv
// Store and restore command interpreter on the serial bus
// Behaviour
// R1 - Register writes stay volatile until stored
// R2 - Store command copies working registers to memory
// R3 - Any reset reloads memory into working registers
// R4 - Nonvolatile-area restore copies memory into registers
// R5 - Rest-area restore reloads remaining registers
// R6 - Host sends start, address, two bytes, stop
// R7 - Soft reset command reloads while idle
// R8 - Acknowledge bytes; act only on complete match
`timescale 1ns/100ps
module nvsr_cmd (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [6:0] dev_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic reg_wr_en,
  input wire logic [1:0] reg_wr_idx,
  input wire logic [15:0] reg_wr_data,
  input wire logic rest_wr_en,
  input wire logic [1:0] rest_wr_idx,
  input wire logic [15:0] rest_wr_data,
  output logic [15:0] work_cfg,
  output logic [15:0] work_alarm_hi,
  output logic [15:0] work_alarm_lo,
  output logic [15:0] work_spare,
  output logic [63:0] rest_area,
  output logic busy,
  output logic soft_reset_pulse
);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic active;
    logic addressed;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [1:0] byte_cnt;
    logic [15:0] cmd;
    logic ack_drive;
    logic [3:0][15:0] work;
    logic [3:0][15:0] rest;
    nvsr_pkg::nvsr_op_e op;
    logic [1:0] idx;
    logic load_pend;
    logic soft_rst;
  } nvsr_state_s;

  nvsr_state_s st_ff;
  nvsr_state_s nxt_st;
  logic mem_we;
  logic [15:0] mem_wd;
  logic [15:0] mem_rd;

  nvsr_mem u_mem (
    .core_clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(st_ff.idx),
    .wr_data(mem_wd),
    .rd_addr(st_ff.idx),
    .rd_data(mem_rd)
  );

  function automatic logic cmd_known(input logic [15:0] c);
    cmd_known = (c == nvsr_pkg::CMD_STORE) || (c == nvsr_pkg::CMD_RESTORE_NV) ||
                (c == nvsr_pkg::CMD_RESTORE_REST) || (c == nvsr_pkg::CMD_SOFT_RESET);
  endfunction

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_s = st_ff.scl_sync[1];
  assign sda_s = st_ff.sda_sync[1];
  assign scl_rise = scl_s && !st_ff.scl_prev;
  assign scl_fall = !scl_s && st_ff.scl_prev;
  assign start_c = scl_s && st_ff.scl_prev && st_ff.sda_prev && !sda_s;
  assign stop_c = scl_s && st_ff.scl_prev && !st_ff.sda_prev && sda_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    mem_we = 1'b0;
    mem_wd = st_ff.work[st_ff.idx];
    nxt_st.soft_rst = 1'b0;
    nxt_st.scl_sync = {st_ff.scl_sync[0], scl_in};
    nxt_st.sda_sync = {st_ff.sda_sync[0], sda_in};
    nxt_st.scl_prev = scl_s;
    nxt_st.sda_prev = sda_s;
    if (reg_wr_en && st_ff.op == nvsr_pkg::NVSR_IDLE && !st_ff.load_pend) begin
      nxt_st.work[reg_wr_idx] = reg_wr_data; // R1
    end
    if (rest_wr_en && st_ff.op == nvsr_pkg::NVSR_IDLE && !st_ff.load_pend) begin
      nxt_st.rest[rest_wr_idx] = rest_wr_data;
    end
    // Serial receiver
    if (start_c) begin
      nxt_st.active = 1'b1;
      nxt_st.addressed = 1'b0;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.byte_cnt = 2'h0;
      nxt_st.ack_drive = 1'b0;
    end else if (stop_c) begin
      nxt_st.active = 1'b0;
      nxt_st.ack_drive = 1'b0;
      if (st_ff.addressed && st_ff.byte_cnt == 2'h3 && cmd_known(st_ff.cmd)
          && st_ff.op == nvsr_pkg::NVSR_IDLE) begin // R6 R8
        case (st_ff.cmd)
          nvsr_pkg::CMD_STORE: begin
            nxt_st.op = nvsr_pkg::NVSR_STORE; // R2
            nxt_st.idx = 2'h0;
          end
          nvsr_pkg::CMD_RESTORE_NV: begin
            nxt_st.op = nvsr_pkg::NVSR_LOAD_RD; // R4
            nxt_st.idx = 2'h0;
          end
          nvsr_pkg::CMD_RESTORE_REST: begin
            nxt_st.op = nvsr_pkg::NVSR_REST_COPY; // R5
          end
          default: begin
            nxt_st.soft_rst = 1'b1; // R7
            nxt_st.op = nvsr_pkg::NVSR_LOAD_RD;
            nxt_st.idx = 2'h0;
          end
        endcase
      end
    end else if (st_ff.active) begin
      if (scl_rise && st_ff.bit_cnt < 4'h8) begin
        nxt_st.shreg = {st_ff.shreg[6:0], sda_s};
        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
      end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
        nxt_st.bit_cnt = 4'h9;
        if (st_ff.byte_cnt == 2'h0) begin
          if (st_ff.shreg == {dev_addr, 1'b0}) begin
            nxt_st.addressed = 1'b1;
            nxt_st.ack_drive = 1'b1; // R8
          end
          nxt_st.byte_cnt = 2'h1;
        end else if (st_ff.addressed && st_ff.byte_cnt != 2'h3) begin
          nxt_st.cmd = {st_ff.cmd[7:0], st_ff.shreg};
          nxt_st.ack_drive = 1'b1; // R8
          nxt_st.byte_cnt = st_ff.byte_cnt + 2'h1;
        end else begin
          nxt_st.byte_cnt = 2'h3;
          nxt_st.addressed = 1'b0;
        end
      end else if (scl_fall && st_ff.bit_cnt == 4'h9) begin
        nxt_st.ack_drive = 1'b0;
        nxt_st.bit_cnt = 4'h0;
        if (!st_ff.addressed) begin
          nxt_st.active = 1'b0;
        end
      end
    end
    // Memory sequencer
    case (st_ff.op)
      nvsr_pkg::NVSR_LOAD_RD: begin
        nxt_st.op = nvsr_pkg::NVSR_LOAD_WR;
      end
      nvsr_pkg::NVSR_LOAD_WR: begin
        nxt_st.work[st_ff.idx] = mem_rd; // R3 R4
        nxt_st.idx = st_ff.idx + 2'h1;
        nxt_st.op = (st_ff.idx == nvsr_pkg::NV_LAST) ? nvsr_pkg::NVSR_IDLE
                                                     : nvsr_pkg::NVSR_LOAD_RD;
      end
      nvsr_pkg::NVSR_STORE: begin
        mem_we = 1'b1; // R2
        nxt_st.idx = st_ff.idx + 2'h1;
        if (st_ff.idx == nvsr_pkg::NV_LAST) begin
          nxt_st.op = nvsr_pkg::NVSR_IDLE;
        end
      end
      nvsr_pkg::NVSR_REST_COPY: begin
        for (int i = 0; i < nvsr_pkg::REST_WORDS; i++) begin
          nxt_st.rest[i] = nvsr_pkg::REST_RST; // R5
        end
        nxt_st.op = nvsr_pkg::NVSR_IDLE;
      end
      default: begin
        if (st_ff.load_pend) begin
          nxt_st.load_pend = 1'b0;
          nxt_st.op = nvsr_pkg::NVSR_LOAD_RD; // R3
          nxt_st.idx = 2'h0;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.scl_sync <= 2'h3;
      st_ff.sda_sync <= 2'h3;
      st_ff.scl_prev <= 1'b1;
      st_ff.sda_prev <= 1'b1;
      st_ff.op <= nvsr_pkg::NVSR_IDLE;
      st_ff.load_pend <= 1'b1; // R3
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = st_ff.ack_drive;
  assign work_cfg = st_ff.work[nvsr_pkg::IDX_CFG];
  assign work_alarm_hi = st_ff.work[nvsr_pkg::IDX_ALARM_HI];
  assign work_alarm_lo = st_ff.work[nvsr_pkg::IDX_ALARM_LO];
  assign work_spare = st_ff.work[nvsr_pkg::IDX_SPARE];
  assign rest_area = st_ff.rest;
  assign busy = (st_ff.op != nvsr_pkg::NVSR_IDLE) || st_ff.load_pend;
  assign soft_reset_pulse = st_ff.soft_rst;

endmodule // nvsr_cmd

// ===== nvsr_cmd_props.sv
// Assertions on the store and restore command block
`timescale 1ns/100ps
module nvsr_cmd_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic reg_wr_en,
  input wire logic [1:0] reg_wr_idx,
  input wire logic [15:0] reg_wr_data,
  input wire logic [15:0] work_cfg,
  input wire logic [63:0] rest_area,
  input wire logic busy,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_reset_clears: assert property (disable iff (1'b0) srst |=> work_cfg == 16'h0000
    && rest_area == 64'h0 && !sda_oe) else $error("reset did not clear state");
  a_reset_reload: assert property ($fell(srst) |-> busy ##[1:20] !busy)
    else $error("reset reload not bounded");
  a_soft_one_cycle: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_soft_reloads: assert property (soft_reset_pulse |-> ##[0:2] busy)
    else $error("soft reset without reload");
  a_regs_hold: assert property (!busy && !reg_wr_en |=> $stable(work_cfg))
    else $error("working register changed unasked");
  a_write_lands: assert property (!busy && reg_wr_en && reg_wr_idx == 2'h0
    |=> work_cfg == $past(reg_wr_data)) else $error("register write lost");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("acknowledge raised with clock high");
  a_drive_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data driven high");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:12] !busy)
    else $error("store or restore did not finish");
endmodule // nvsr_cmd_props
bind nvsr_cmd nvsr_cmd_props u_props (.core_clk(core_clk), .srst(srst), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx),
  .reg_wr_data(reg_wr_data), .work_cfg(work_cfg), .rest_area(rest_area), .busy(busy),
  .soft_reset_pulse(soft_reset_pulse));

// ===== nvsr_host.sv
// Bus master model that sends command frames
`timescale 1ns/100ps
module nvsr_host (
  input wire logic core_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda = d;
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  // Start, address with write, command high then low byte, stop
  task automatic frame(input logic [6:0] adr, input logic [15:0] cmd, output int acks);
    logic [23:0] sh;
    logic b;
    sh = {adr, 1'b0, cmd};
    acks = 0;
    ph(1'b1, 1'b0);
    for (int i = 0; i < 27; i++) begin
      b = (i % 9 == 8) ? 1'b1 : sh[23 - (i - i / 9)];
      ph(1'b0, sda);
      ph(1'b0, b);
      ph(1'b1, b);
      if (i % 9 == 8 && sda_in === 1'b0) acks++;
    end
    ph(1'b0, sda);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
endmodule // nvsr_host

// ===== tb_nvsr_cmd.sv
// Testbench of the store and restore command block
`timescale 1ns/100ps
module tb_nvsr_cmd;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] pre;
    logic [15:0] cfg;
    logic [15:0] rst;
    logic pls;
  } nvsr_row_s;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic rest_wr_en = 1'b0;
  logic [1:0] idx = 2'h0;
  logic [15:0] wd = 16'h0000;
  logic scl, h_sda, sda_out, sda_oe, busy, soft_reset_pulse;
  logic [15:0] work_cfg;
  logic [15:0] work_alarm_hi;
  logic [15:0] work_alarm_lo;
  logic [15:0] work_spare;
  logic [63:0] rest_area;
  wire logic sda_w = h_sda & (sda_oe ? sda_out : 1'b1);
  int n_mismatch = 0;
  int total_checks = 0;
  int pulses = 0;
  int cyc = 0;
  int acks;
  nvsr_row_s rows [5] = '{
    '{nvsr_pkg::CMD_STORE, 16'h1234, 16'h1234, 16'h2222, 1'b0},
    '{nvsr_pkg::CMD_RESTORE_NV, 16'h5678, 16'h1234, 16'h2222, 1'b0},
    '{nvsr_pkg::CMD_RESTORE_REST, 16'h5678, 16'h5678, 16'h0000, 1'b0},
    '{nvsr_pkg::CMD_SOFT_RESET, 16'h9ABC, 16'h1234, 16'h2222, 1'b1},
    '{16'hCC49, 16'h5678, 16'h5678, 16'h2222, 1'b0}};
  nvsr_cmd dut (.core_clk(core_clk), .srst(srst), .dev_addr(nvsr_pkg::DEV_ADDR_DEFAULT),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .reg_wr_en(reg_wr_en),
    .reg_wr_idx(idx), .reg_wr_data(wd), .rest_wr_en(rest_wr_en), .rest_wr_idx(idx),
    .rest_wr_data(wd), .work_cfg(work_cfg), .work_alarm_hi(work_alarm_hi),
    .work_alarm_lo(work_alarm_lo), .work_spare(work_spare), .rest_area(rest_area),
    .busy(busy), .soft_reset_pulse(soft_reset_pulse));
  nvsr_host u_host (.core_clk(core_clk), .sda_in(sda_w), .scl(scl), .sda(h_sda));
  always #20 core_clk = ~core_clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic r, input logic [1:0] a, input logic [15:0] d);
    idx = a;
    wd = d;
    reg_wr_en = r;
    rest_wr_en = ~r;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    rest_wr_en = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic idle();
    repeat (3) @(posedge core_clk);
    #1;
    for (int i = 0; i < 60 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (soft_reset_pulse === 1'b1) pulses++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    idle();
    foreach (rows[i]) begin
      wr(1'b1, 2'h0, rows[i].pre);
      wr(1'b0, 2'h0, 16'h2222);
      pulses = 0;
      u_host.frame(nvsr_pkg::DEV_ADDR_DEFAULT, rows[i].cmd, acks);
      idle();
      chk16(16'(acks), 16'h0003);
      chk16(work_cfg, rows[i].cfg);
      chk16(rest_area[15:0], rows[i].rst);
      chk16(16'(pulses), {15'h0000, rows[i].pls});
    end
    u_host.frame(nvsr_pkg::DEV_ADDR_DEFAULT ^ 7'h01, nvsr_pkg::CMD_RESTORE_NV, acks);
    idle();
    chk16(16'(acks), 16'h0000);
    chk16(work_cfg, 16'h5678);
    for (int k = 0; k < 4; k++) begin
      wr(1'b1, 2'(k), 16'hA0A0 + 16'(k));
    end
    u_host.frame(nvsr_pkg::DEV_ADDR_DEFAULT, nvsr_pkg::CMD_STORE, acks);
    idle();
    for (int k = 0; k < 4; k++) begin
      wr(1'b1, 2'(k), 16'h0F0F);
    end
    chk16(work_alarm_hi, 16'h0F0F);
    chk16(work_spare, 16'h0F0F);
    wr(1'b0, 2'h3, 16'h3333);
    chk16(rest_area[63:48], 16'h3333);
    u_host.frame(nvsr_pkg::DEV_ADDR_DEFAULT, nvsr_pkg::CMD_RESTORE_NV, acks);
    idle();
    chk16(work_cfg, 16'hA0A0);
    chk16(work_alarm_hi, 16'hA0A1);
    chk16(work_alarm_lo, 16'hA0A2);
    chk16(work_spare, 16'hA0A3);
    chk16(rest_area[63:48], 16'h3333);
    u_host.frame(nvsr_pkg::DEV_ADDR_DEFAULT, nvsr_pkg::CMD_RESTORE_REST, acks);
    idle();
    chk16(rest_area[63:48], 16'h0000);
    chk16(work_alarm_lo, 16'hA0A2);
    srst = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk16(work_cfg, 16'h0000);
    chk16(work_spare, 16'h0000);
    srst = 1'b0;
    idle();
    chk16(work_cfg, 16'hA0A0);
    chk16(work_alarm_hi, 16'hA0A1);
    chk16(work_alarm_lo, 16'hA0A2);
    chk16(work_spare, 16'hA0A3);
    final_report();
  end
endmodule // tb_nvsr_cmd
